/* core/stcp_defs.vh */
/*
 * shared constants of the serial terminal command parser: frame bytes,
 * opcodes, parameter codes, key codes, register offsets, defaults, timing.
 * assumes it is included by bare name from the design files.
 */
`ifndef STCP_DEFS_VH
`define STCP_DEFS_VH

// frame and reply bytes
`define STCP_STX          8'h02
`define STCP_ETX          8'h03
`define STCP_ACK          8'h06
`define STCP_NAK          8'h15

// opcodes
`define STCP_OP_VER       8'h56
`define STCP_OP_SHOW      8'h44
`define STCP_OP_ERASE     8'h43
`define STCP_OP_READER    8'h4D
`define STCP_OP_KEYPAD    8'h4B
`define STCP_OP_BEEP      8'h42
`define STCP_OP_PARAM     8'h50
`define STCP_OP_GSAVE     8'h53

// parameter byte codes
`define STCP_CH_0         8'h30
`define STCP_CH_1         8'h31
`define STCP_CH_2         8'h32
`define STCP_CH_3         8'h33
`define STCP_TPAGE_MAX    8'h3C
`define STCP_GPAGE_MAX    8'h36

// version string letters
`define STCP_CH_R         8'h52
`define STCP_CH_O         8'h4F
`define STCP_CH_M         8'h4D
`define STCP_CH_SP        8'h20
`define STCP_CH_STAR      8'h2A
`define STCP_VER_LEN      4'h0a

// keypad codes
`define STCP_ENTER_KEY    8'h0D
`define STCP_KEY_CLR      8'h08
`define STCP_KEY_ESC      8'h1B
`define STCP_KEY_MAX      6'h20

// status byte field positions
`define STCP_ST_KP        5
`define STCP_ST_RD        4
`define STCP_ST_DISP      3
`define STCP_ST_MODE      2

// factory defaults
`define STCP_DEF_BAUD     2'h2
`define STCP_DEF_BUF      1'h1
`define STCP_DEF_MASK     1'h0

// register byte offsets
`define STCP_REG_STATUS   8'h00
`define STCP_REG_KEY      8'h04
`define STCP_REG_PAGE     8'h08
`define STCP_REG_KCNT     8'h0C

// timing: one buzzer bit is 0.1 s worth of 100 ns clocks
`define STCP_CLK_NS       100
`define STCP_BEEP_NS      100000000
`define STCP_BEEP_CYC     24'h0F_4240

`endif

/* core/stcp_top.v */
/*
 * command interpreter of a keypad, reader and display terminal: frames, settings, keys, beep.
 * assumes a uart that strobes received bytes and takes one while tx_ready is high, and a
 * nonvolatile store that presents its saved settings while rst_n is released.
 */
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "stcp_defs.vh"
module stcp_top #(
	parameter [23:0] BEEP_CYC = `STCP_BEEP_CYC,
	parameter [31:0] FW_ID    = 32'h3030_3031, // arbitrary value
	parameter [7:0]  REV_ID   = 8'h41         // arbitrary value
) (
	// clock and reset
	input  wire       ref_clk,
	input  wire       rst_n,
	// straps and stored settings
	input  wire       gfx_model,
	input  wire       nv_ok,
	input  wire [5:0] nv_cfg,
	// received byte stream
	input  wire [7:0] rx_data,
	input  wire       rx_valid,
	// transmitted byte stream
	output reg  [7:0] tx_data_r,
	output reg        tx_valid_r,
	input  wire       tx_ready,
	// register port
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata_r,
	// settings in force
	output reg  [1:0] baud_sel_r,
	output reg        buf_mode_r,
	output reg        mask_r,
	output reg        rd_en_r,
	output reg        kp_en_r,
	// nonvolatile write
	output reg        nv_wr_r,
	output reg  [5:0] nv_wdata_r,
	// display
	output reg        disp_clear_r,
	output reg        page_show_r,
	output reg        page_gfx_r,
	output reg  [3:0] page_num_r,
	output reg        gfx_save_r,
	output reg  [7:0] disp_char_r,
	output reg        disp_char_vld_r,
	// buzzer
	output reg        buzzer_r
);

	// parser states
	localparam [4:0] S_IDLE = 5'b00001;
	localparam [4:0] S_OP   = 5'b00010;
	localparam [4:0] S_PAR  = 5'b00100;
	localparam [4:0] S_END  = 5'b01000;
	localparam [4:0] S_RESP = 5'b10000;

	reg  [4:0]  state_r, dptr_r;
	reg  [7:0]  op_r, m_r, n_r, beep_arg_r, beep_pat_r;
	reg  [1:0]  npar_r;
	reg  [3:0]  ridx_r, beep_bits_r;
	reg  [5:0]  kcnt_r;
	reg  [23:0] beep_tick_r;
	reg         ok_r, ver_r, load_r, gfx_r, drain_r, beep_go_r;
	reg  [7:0]  kbuf [0:31];
	reg         cmd_ok;
	reg  [1:0]  par_cnt;
	reg  [7:0]  ver_byte;
	wire [7:0]  status_byte;
	wire [5:0]  nv_next;
	wire        tx_free, txt_n_ok, gfx_n_ok;
	wire        key_wr, enter_key, key_clr, key_esc, key_push;

	// status byte, top two bits zero
	assign status_byte = {2'b00, kp_en_r, rd_en_r, gfx_r, buf_mode_r, baud_sel_r};
	assign tx_free     = tx_ready & ~tx_valid_r;
	assign txt_n_ok    = (n_r >= `STCP_CH_1) && (n_r <= `STCP_TPAGE_MAX);
	assign gfx_n_ok    = (n_r >= `STCP_CH_1) && (n_r <= `STCP_GPAGE_MAX);
	// key entry decode, refused while disabled or sending
	assign key_wr    = reg_wr && (reg_addr == `STCP_REG_KEY) && kp_en_r && !drain_r && !load_r;
	assign enter_key = key_wr && (reg_wdata == `STCP_ENTER_KEY);
	assign key_clr   = key_wr && (reg_wdata == `STCP_KEY_CLR);
	assign key_esc   = key_wr && (reg_wdata == `STCP_KEY_ESC);
	assign key_push  = key_wr && !enter_key && !key_clr && !key_esc &&
	                   (kcnt_r < `STCP_KEY_MAX);
	// settings word written to the store after an accepted change
	assign nv_next = (op_r == `STCP_OP_READER) ? {kp_en_r, n_r[0], mask_r, buf_mode_r, baud_sel_r} :
	                 (op_r == `STCP_OP_KEYPAD) ? {n_r[0], rd_en_r, mask_r, buf_mode_r, baud_sel_r} :
	                 (m_r == `STCP_CH_1) ? {kp_en_r, rd_en_r, mask_r, buf_mode_r, n_r[1:0]} :
	                 (m_r == `STCP_CH_2) ? {kp_en_r, rd_en_r, mask_r, n_r[0], baud_sel_r} :
	                 {kp_en_r, rd_en_r, n_r[0], buf_mode_r, baud_sel_r};

	// parameter bytes expected per opcode, unknown opcodes take none
	always @* begin
		case (rx_data)
			`STCP_OP_READER, `STCP_OP_KEYPAD, `STCP_OP_BEEP, `STCP_OP_GSAVE: par_cnt = 2'd1;
			`STCP_OP_SHOW, `STCP_OP_PARAM: par_cnt = 2'd2;
			default: par_cnt = 2'd0;
		endcase
	end

	// acceptance of a complete frame
	always @* begin
		case (op_r)
			`STCP_OP_VER, `STCP_OP_ERASE, `STCP_OP_BEEP: cmd_ok = 1'b1;
			`STCP_OP_SHOW: cmd_ok = ((m_r == `STCP_CH_0) && txt_n_ok) ||
			                        ((m_r == `STCP_CH_1) && gfx_r && gfx_n_ok);
			`STCP_OP_READER, `STCP_OP_KEYPAD: cmd_ok = (n_r == `STCP_CH_0) || (n_r == `STCP_CH_1);
			`STCP_OP_PARAM: cmd_ok = ((m_r == `STCP_CH_1) && (n_r >= `STCP_CH_0) && (n_r <= `STCP_CH_3)) ||
			                         (((m_r == `STCP_CH_2) || (m_r == `STCP_CH_3)) &&
			                          ((n_r == `STCP_CH_0) || (n_r == `STCP_CH_1)));
			`STCP_OP_GSAVE: cmd_ok = gfx_r && gfx_n_ok;
			default: cmd_ok = 1'b0;
		endcase
	end

	// version string byte by index
	always @* begin
		case (ridx_r)
			4'd0: ver_byte = `STCP_CH_R;
			4'd1: ver_byte = `STCP_CH_O;
			4'd2: ver_byte = `STCP_CH_M;
			4'd3: ver_byte = FW_ID[31:24];
			4'd4: ver_byte = FW_ID[23:16];
			4'd5: ver_byte = FW_ID[15:8];
			4'd6: ver_byte = FW_ID[7:0];
			4'd7: ver_byte = REV_ID;
			4'd8: ver_byte = `STCP_CH_SP;
			default: ver_byte = status_byte;
		endcase
	end

	// key buffer storage, keeps real key codes
	always @(posedge ref_clk) begin
		if (key_push) begin
			kbuf[kcnt_r[4:0]] <= reg_wdata;
		end
	end

	// parser, settings, key buffer bookkeeping and byte sender
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r         <= S_IDLE;
			op_r            <= 8'h00;
			m_r             <= 8'h00;
			n_r             <= 8'h00;
			npar_r          <= 2'd0;
			ok_r            <= 1'b0;
			ver_r           <= 1'b0;
			ridx_r          <= 4'd0;
			load_r          <= 1'b1;
			gfx_r           <= 1'b0;
			baud_sel_r      <= `STCP_DEF_BAUD;
			buf_mode_r      <= `STCP_DEF_BUF;
			mask_r          <= `STCP_DEF_MASK;
			rd_en_r         <= 1'b1;
			kp_en_r         <= 1'b1;
			nv_wr_r         <= 1'b0;
			nv_wdata_r      <= 6'h00;
			disp_clear_r    <= 1'b0;
			page_show_r     <= 1'b0;
			page_gfx_r      <= 1'b0;
			page_num_r      <= 4'h1;
			gfx_save_r      <= 1'b0;
			disp_char_r     <= 8'h00;
			disp_char_vld_r <= 1'b0;
			kcnt_r          <= 6'd0;
			dptr_r          <= 5'd0;
			drain_r         <= 1'b0;
			beep_go_r       <= 1'b0;
			beep_arg_r      <= 8'h00;
			tx_data_r       <= 8'h00;
			tx_valid_r      <= 1'b0;
		end else begin
			nv_wr_r         <= 1'b0;
			disp_clear_r    <= 1'b0;
			page_show_r     <= 1'b0;
			gfx_save_r      <= 1'b0;
			disp_char_vld_r <= 1'b0;
			beep_go_r       <= 1'b0;
			tx_valid_r      <= 1'b0;
			// first cycle after release: take strap and stored baud, buffer mode and mask
			if (load_r) begin
				load_r <= 1'b0;
				gfx_r  <= gfx_model;
				if (nv_ok) begin
					baud_sel_r <= nv_cfg[1:0];
					buf_mode_r <= nv_cfg[2];
					mask_r     <= nv_cfg[3];
				end
			end
			// frame parsing, bytes during a reply are ignored
			case (state_r)
				S_IDLE: begin
					state_r <= (rx_valid && (rx_data == `STCP_STX)) ? S_OP : S_IDLE;
				end
				S_OP: begin
					if (rx_valid) begin
						op_r   <= rx_data;
						npar_r <= par_cnt;
						state_r <= (par_cnt == 2'd0) ? S_END : S_PAR;
					end
				end
				S_PAR: begin
					if (rx_valid) begin
						m_r    <= n_r;
						n_r    <= rx_data;
						npar_r <= npar_r - 2'd1;
						state_r <= (npar_r == 2'd1) ? S_END : S_PAR;
					end
				end
				S_END: begin
					if (rx_valid) begin
						ok_r    <= (rx_data == `STCP_ETX) && cmd_ok;
						ver_r   <= (rx_data == `STCP_ETX) && (op_r == `STCP_OP_VER);
						ridx_r  <= 4'd0;
						state_r <= S_RESP;
						if ((rx_data == `STCP_ETX) && cmd_ok) begin
							case (op_r)
								`STCP_OP_SHOW: begin
									page_show_r <= 1'b1;
									page_gfx_r  <= m_r[0];
									page_num_r  <= n_r[3:0];
								end
								`STCP_OP_READER: begin
									rd_en_r    <= n_r[0];
									nv_wr_r    <= 1'b1;
									nv_wdata_r <= nv_next;
								end
								`STCP_OP_KEYPAD: begin
									kp_en_r    <= n_r[0];
									nv_wr_r    <= 1'b1;
									nv_wdata_r <= nv_next;
								end
								`STCP_OP_PARAM: begin
									baud_sel_r <= nv_next[1:0];
									buf_mode_r <= nv_next[2];
									mask_r     <= nv_next[3];
									nv_wr_r    <= 1'b1;
									nv_wdata_r <= nv_next;
								end
								`STCP_OP_BEEP: begin
									beep_go_r  <= 1'b1;
									beep_arg_r <= n_r;
								end
								`STCP_OP_GSAVE: gfx_save_r <= 1'b1;
								default: ;
							endcase
						end
					end
				end
				S_RESP: begin
					if (tx_free) begin
						tx_valid_r <= 1'b1;
						tx_data_r  <= ver_r ? ver_byte : (ok_r ? `STCP_ACK : `STCP_NAK);
						ridx_r     <= ridx_r + 4'd1;
						state_r    <= (!ver_r || (ridx_r == `STCP_VER_LEN - 4'd1)) ? S_IDLE : S_RESP;
					end
				end
				default: state_r <= S_IDLE;
			endcase
			// key buffer, erase command has the last word
			if (drain_r) begin
				if (tx_free && (state_r != S_RESP)) begin
					tx_valid_r <= 1'b1;
					tx_data_r  <= kbuf[dptr_r];
					dptr_r     <= dptr_r + 5'd1;
					if ({1'b0, dptr_r} == kcnt_r - 6'd1) begin
						drain_r <= 1'b0;
						kcnt_r  <= 6'd0;
					end
				end
			end else if (key_push) begin
				kcnt_r          <= kcnt_r + 6'd1;
				disp_char_r     <= mask_r ? `STCP_CH_STAR : reg_wdata;
				disp_char_vld_r <= 1'b1;
				disp_clear_r    <= buf_mode_r && (kcnt_r == 6'd0); // first key in buffered mode clears the screen
				if (!buf_mode_r) begin
					drain_r <= 1'b1;
					dptr_r  <= 5'd0;
				end
			end else if (enter_key && buf_mode_r && (kcnt_r != 6'd0)) begin
				drain_r      <= 1'b1;
				dptr_r       <= 5'd0;
				disp_clear_r <= 1'b1;
			end else if (key_clr && (kcnt_r != 6'd0)) begin
				kcnt_r <= kcnt_r - 6'd1;
			end else if (key_esc) begin
				kcnt_r       <= 6'd0;
				disp_clear_r <= 1'b1;
			end
			if ((state_r == S_END) && rx_valid && (rx_data == `STCP_ETX) &&
			    (op_r == `STCP_OP_ERASE)) begin
				kcnt_r       <= 6'd0;
				drain_r      <= 1'b0;
				disp_clear_r <= 1'b1;
			end
		end
	end

	// buzzer pattern player, one bit per tick, msb first
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			beep_pat_r  <= 8'h00;
			beep_bits_r <= 4'd0;
			beep_tick_r <= 24'd0;
			buzzer_r    <= 1'b0;
		end else if (beep_go_r) begin
			beep_pat_r  <= beep_arg_r;
			beep_bits_r <= 4'd8;
			beep_tick_r <= 24'd0;
			buzzer_r    <= beep_arg_r[7];
		end else if (beep_bits_r != 4'd0) begin
			if (beep_tick_r == BEEP_CYC - 24'd1) begin
				beep_tick_r <= 24'd0;
				beep_pat_r  <= {beep_pat_r[6:0], 1'b0};
				beep_bits_r <= beep_bits_r - 4'd1;
				buzzer_r    <= (beep_bits_r != 4'd1) && beep_pat_r[6];
			end else begin
				beep_tick_r <= beep_tick_r + 24'd1;
			end
		end
	end

	// register read port, data one cycle after the strobe
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`STCP_REG_STATUS: reg_rdata_r <= status_byte;
				`STCP_REG_PAGE:   reg_rdata_r <= {3'b000, page_gfx_r, page_num_r};
				`STCP_REG_KCNT:   reg_rdata_r <= {2'b00, kcnt_r};
				default:          reg_rdata_r <= 8'h00;
			endcase
		end else begin
			reg_rdata_r <= 8'h00;
		end
	end

endmodule // stcp_top

/* dv/stcp_chk_sva.sv */
/* port checker for the command parser: read port, reply stream, settings, display.
   assumes it is bound into stcp_top and sees its ports only. */
`timescale 1ns/100ps
module stcp_chk (
	// clock and reset
	input wire       ref_clk,
	input wire       rst_n,
	// strap, read port, reply stream
	input wire       gfx_model,
	input wire       reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_rdata_r,
	input wire       tx_ready,
	input wire       tx_valid_r,
	// settings and nonvolatile write
	input wire [1:0] baud_sel_r,
	input wire       buf_mode_r,
	input wire       mask_r,
	input wire       rd_en_r,
	input wire       kp_en_r,
	input wire       nv_wr_r,
	input wire [5:0] nv_wdata_r,
	// display
	input wire       page_show_r,
	input wire       page_gfx_r,
	input wire [3:0] page_num_r,
	input wire       gfx_save_r,
	input wire [7:0] disp_char_r,
	input wire       disp_char_vld_r
);
	reg [1:0] up_r;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// cycles since reset release, so the load cycle is not taken for a change
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			up_r <= 2'h0;
		else if (up_r != 2'h3)
			up_r <= up_r + 2'h1;
	end
	a_reset_state: assert property (
		!$past(rst_n) |-> rd_en_r && kp_en_r && baud_sel_r == 2'h2 && buf_mode_r)
		else $error("restart state wrong");
	a_status_read: assert property (
		reg_rd && reg_addr == 8'h00 |=> reg_rdata_r == {2'h0, $past(kp_en_r),
		$past(rd_en_r), $past(gfx_model), $past(buf_mode_r), $past(baud_sel_r)})
		else $error("status byte wrong");
	a_tx_spacing: assert property (tx_valid_r |=> !tx_valid_r)
		else $error("reply bytes too close");
	a_tx_ready: assert property (tx_valid_r |-> $past(tx_ready))
		else $error("byte sent without ready");
	a_nv_copy: assert property (
		nv_wr_r |-> nv_wdata_r == {kp_en_r, rd_en_r, mask_r, buf_mode_r, baud_sel_r})
		else $error("stored settings differ");
	a_set_hold: assert property (
		up_r[1] && ($changed(baud_sel_r) || $changed(buf_mode_r) || $changed(mask_r)
		|| $changed(rd_en_r) || $changed(kp_en_r)) |-> nv_wr_r)
		else $error("setting changed without store");
	a_page_range: assert property (
		page_show_r |-> page_num_r >= 4'h1 && page_num_r <= (page_gfx_r ? 4'h6 : 4'hC))
		else $error("page number out of range");
	a_gfx_only: assert property (
		(page_show_r && page_gfx_r) || gfx_save_r |-> gfx_model)
		else $error("graphic action on character model");
	a_mask_char: assert property (
		disp_char_vld_r && mask_r |-> disp_char_r == 8'h2A)
		else $error("masked display shows key");
endmodule // stcp_chk

bind stcp_top stcp_chk u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .gfx_model(gfx_model), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_rdata_r(reg_rdata_r), .tx_ready(tx_ready),
	.tx_valid_r(tx_valid_r), .baud_sel_r(baud_sel_r), .buf_mode_r(buf_mode_r),
	.mask_r(mask_r), .rd_en_r(rd_en_r), .kp_en_r(kp_en_r), .nv_wr_r(nv_wr_r),
	.nv_wdata_r(nv_wdata_r), .page_show_r(page_show_r), .page_gfx_r(page_gfx_r),
	.page_num_r(page_num_r), .gfx_save_r(gfx_save_r), .disp_char_r(disp_char_r),
	.disp_char_vld_r(disp_char_vld_r)
);

/* dv/stcp_host_model.sv */
/* host side of the serial link: sends command frames as byte strobes, takes replies.
   assumes the parser samples rx on rising ref_clk and sends a byte per tx_valid_r. */
`timescale 1ns/100ps
`include "stcp_defs.vh"
module stcp_host_model (
	// clock
	input  wire       ref_clk,
	// byte streams
	output reg  [7:0] rx_data,
	output reg        rx_valid,
	output reg        tx_ready,
	input  wire [7:0] tx_data_r,
	input  wire       tx_valid_r
);
	logic [7:0] rq[$];
	bit         slow = 1'b0;
	int         ph   = 0;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// collect replies; when slow, ready only every fourth cycle
	always @(posedge ref_clk) begin
		if (tx_valid_r === 1'b1)
			rq.push_back(tx_data_r);
		ph <= ph + 1;
		tx_ready <= !slow || (ph % 4 == 3);
	end
	// one byte strobe; afterwards the line shows the inverse
	task put(input [7:0] b);
		@(posedge ref_clk);
		rx_data <= b;
		rx_valid <= 1'b1;
		@(posedge ref_clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
	endtask
	// start byte, opcode, np parameters, closing byte
	task frame(input [7:0] op, m, n, input int np, input [7:0] eb);
		put(`STCP_STX);
		put(op);
		if (np > 0) put(m);
		if (np > 1) put(n);
		put(eb);
	endtask
	// oldest reply byte, bounded wait
	task get(output [7:0] b, output bit ok);
		int i;
		#1;
		for (i = 0; i < 400 && rq.size() == 0; i++) @(posedge ref_clk) #1;
		ok = rq.size() != 0;
		b = ok ? rq.pop_front() : 8'h00;
	endtask
endmodule // stcp_host_model

/* dv/tb_top.sv */
/* self-checking bench of the command parser: frames, register port, keys, beep.
   assumes the host model answers the reply stream and BEEP_CYC is four. */
`timescale 1ns/100ps
`include "stcp_defs.vh"
module tb_top;
	localparam [31:0] FW = 32'h3132_3334; // arbitrary value
	localparam [7:0]  RV = 8'h42;         // arbitrary value
	localparam [8:0]  BZ = 9'h1EA;        // pattern f5, then silence
	reg         ref_clk, rst_n, gfx_model, nv_ok, reg_wr, reg_rd;
	reg   [5:0] nv_cfg;
	reg   [7:0] reg_addr, reg_wdata, rv;
	reg   [7:0] n_clr = 8'h00, clr0;
	wire  [7:0] rx_data, tx_data_r, reg_rdata_r, disp_char_r;
	wire        rx_valid, tx_ready, tx_valid_r, rd_en_r, kp_en_r, buzzer_r;
	wire        buf_mode_r, mask_r, disp_char_vld_r, disp_clear_r;
	wire  [1:0] baud_sel_r;
	logic [7:0] ver [10];
	logic [7:0] bad [4];
	int         n_mismatch = 0, samples_checked = 0, i;
	stcp_top #(.BEEP_CYC(24'h00_0004), .FW_ID(FW), .REV_ID(RV)) i_stcp_top (
		.ref_clk(ref_clk), .rst_n(rst_n), .gfx_model(gfx_model), .nv_ok(nv_ok),
		.nv_cfg(nv_cfg), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data_r(tx_data_r),
		.tx_valid_r(tx_valid_r), .tx_ready(tx_ready), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.baud_sel_r(baud_sel_r), .buf_mode_r(buf_mode_r), .mask_r(mask_r),
		.rd_en_r(rd_en_r), .kp_en_r(kp_en_r), .nv_wr_r(), .nv_wdata_r(),
		.disp_clear_r(disp_clear_r), .page_show_r(), .page_gfx_r(), .page_num_r(), .gfx_save_r(),
		.disp_char_r(disp_char_r), .disp_char_vld_r(disp_char_vld_r), .buzzer_r(buzzer_r));
	stcp_host_model host (.ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_ready(tx_ready), .tx_data_r(tx_data_r), .tx_valid_r(tx_valid_r));
	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// count display clear pulses for the erase check
	always @(posedge ref_clk) if (disp_clear_r === 1'b1) n_clr <= n_clr + 8'h01;
	task stop_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task lost;
		n_mismatch++;
		$display("wrong value at %0t: wait ran out", $time);
		stop_test();
	endtask
	task chk(input [7:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input [7:0] a, d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata_r;
	endtask
	task reply(input [7:0] exp);
		reg [7:0] b;
		bit       ok;
		host.get(b, ok);
		if (!ok) lost();
		chk(b, exp);
	endtask
	task cmd(input [7:0] op, m, n, input int np, input [7:0] exp);
		host.frame(op, m, n, np, `STCP_ETX);
		reply(exp);
	endtask
	task restart;
		rst_n <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		gfx_model = 1'b0;
		nv_ok = 1'b1;
		nv_cfg = 6'h01;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ver = '{`STCP_CH_R, `STCP_CH_O, `STCP_CH_M, FW[31:24], FW[23:16], FW[15:8],
			FW[7:0], RV, `STCP_CH_SP, 8'h31};
		bad = '{8'h40, 8'h46, 8'h59, 8'h5A};
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1 chk({2'h0, kp_en_r, rd_en_r, mask_r, buf_mode_r, baud_sel_r}, 8'h36);
		repeat (3) @(posedge ref_clk);
		rd(8'h00);
		chk(rv, 8'h31);
		host.frame(`STCP_OP_VER, 8'h00, 8'h00, 0, `STCP_ETX);
		for (i = 0; i < 10; i++) reply(ver[i]);
		for (i = 0; i < 4; i++) begin
			cmd(`STCP_OP_PARAM, `STCP_CH_1, 8'h30 + i[7:0], 2, `STCP_ACK);
			rd(8'h00);
			chk(rv & 8'h03, i[7:0]);
		end
		cmd(`STCP_OP_PARAM, `STCP_CH_2, `STCP_CH_1, 2, `STCP_ACK);
		cmd(`STCP_OP_PARAM, `STCP_CH_3, `STCP_CH_1, 2, `STCP_ACK);
		cmd(`STCP_OP_PARAM, `STCP_CH_1, 8'h34, 2, `STCP_NAK);
		cmd(`STCP_OP_PARAM, 8'h34, `STCP_CH_0, 2, `STCP_NAK);
		for (i = 0; i < 4; i++) cmd(bad[i], 8'h00, 8'h00, 0, `STCP_NAK);
		cmd(`STCP_OP_GSAVE, `STCP_CH_1, 8'h00, 1, `STCP_NAK);
		host.frame(`STCP_OP_ERASE, 8'h00, 8'h00, 0, 8'h31);
		reply(`STCP_NAK);
		chk({4'h0, baud_sel_r, buf_mode_r, mask_r}, 8'h0F);
		cmd(`STCP_OP_SHOW, `STCP_CH_0, `STCP_TPAGE_MAX, 2, `STCP_ACK);
		rd(8'h08);
		chk(rv, 8'h0C);
		cmd(`STCP_OP_SHOW, `STCP_CH_0, 8'h3D, 2, `STCP_NAK);
		cmd(`STCP_OP_SHOW, `STCP_CH_1, `STCP_CH_1, 2, `STCP_NAK);
		// buffered and masked keys
		wr(8'h04, 8'h31);
		wr(8'h04, 8'h32);
		rd(8'h0C);
		chk(rv, 8'h02);
		wr(8'h04, `STCP_KEY_CLR);
		rd(8'h0C);
		chk(rv, 8'h01);
		clr0 = n_clr;
		cmd(`STCP_OP_ERASE, 8'h00, 8'h00, 0, `STCP_ACK);
		chk(n_clr - clr0, 8'h01);
		rd(8'h0C);
		chk(rv, 8'h00);
		for (i = 0; i < 33; i++) wr(8'h04, 8'h35);
		rd(8'h0C);
		chk(rv, 8'h20);
		wr(8'h04, `STCP_KEY_ESC);
		rd(8'h0C);
		chk(rv, 8'h00);
		host.slow = 1'b1;
		wr(8'h04, 8'h33);
		wr(8'h04, 8'h34);
		wr(8'h04, `STCP_ENTER_KEY);
		reply(8'h33);
		reply(8'h34);
		host.slow = 1'b0;
		// reader and keypad off, keys ignored
		cmd(`STCP_OP_READER, `STCP_CH_0, 8'h00, 1, `STCP_ACK);
		cmd(`STCP_OP_KEYPAD, `STCP_CH_0, 8'h00, 1, `STCP_ACK);
		rd(8'h00);
		chk(rv & 8'h30, 8'h00);
		wr(8'h04, 8'h31);
		rd(8'h0C);
		chk(rv, 8'h00);
		cmd(`STCP_OP_READER, `STCP_CH_2, 8'h00, 1, `STCP_NAK);
		cmd(`STCP_OP_KEYPAD, `STCP_CH_1, 8'h00, 1, `STCP_ACK);
		cmd(`STCP_OP_PARAM, `STCP_CH_2, `STCP_CH_0, 2, `STCP_ACK);
		wr(8'h04, 8'h35);
		reply(8'h35);
		// beep pattern, sampled mid bit
		host.frame(`STCP_OP_BEEP, 8'hF5, 8'h00, 1, `STCP_ETX);
		for (i = 0; i < 20 && buzzer_r !== 1'b1; i++) @(posedge ref_clk) #1;
		if (i == 20) lost();
		#200;
		for (i = 0; i < 9; i++) begin
			chk({7'h00, buzzer_r}, {7'h00, BZ[8 - i]});
			#(4 * 100);
		end
		reply(`STCP_ACK);
		// graphic model restart with reader and keypad stored off
		nv_cfg <= 6'h00;
		gfx_model <= 1'b1;
		restart();
		rd(8'h00);
		chk(rv, 8'h38);
		cmd(`STCP_OP_SHOW, `STCP_CH_1, `STCP_GPAGE_MAX, 2, `STCP_ACK);
		rd(8'h08);
		chk(rv, 8'h16);
		cmd(`STCP_OP_GSAVE, `STCP_CH_1, 8'h00, 1, `STCP_ACK);
		// restart with no valid store: factory defaults in force
		nv_ok <= 1'b0;
		restart();
		rd(8'h00);
		chk(rv, 8'h3E);
		stop_test();
	end
endmodule // tb_top
